// File: drive_output_conditioner.sv
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module drive_output_conditioner
  import drive_output_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)(
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic [ADDR_W-1:0]   address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  output logic [31:0]              readdata,
  output logic                     waitrequest,
  input  wire logic [NUM_SRC-1:0]  eventFlags,
  input  wire logic                localRemoteInUse,
  input  wire logic                extIoPresent,
  input  wire logic                relayModPresent,
  input  wire logic [1:0]          virtualInputSource,
  output logic [NUM_OUT-1:0]       outputs
);

  // ==========================================
  // state
  typedef struct packed {
    logic [NUM_OUT-1:0][SRC_W-1:0] src;
    logic [NUM_OUT-1:0][DLY_W-1:0] onDly;
    logic [NUM_OUT-1:0][DLY_W-1:0] holdDly;
    logic [NUM_OUT-1:0]            negPol;
    logic [NUM_OUT-1:0][DLY_W-1:0] cnt;
    logic [NUM_OUT-1:0][1:0]       st;
    logic [NUM_OUT-1:0]            evState;
    logic [NUM_OUT-1:0]            outs;
    logic [31:0]                   tick;
    logic                          msPulse;
    logic [NUM_SRC-1:0]            evMeta;
    logic [NUM_SRC-1:0]            evSync;
    logic [4:0]                    modMeta;
    logic [4:0]                    modSync;
    logic [31:0]                   rdata;
    logic                          ack;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // ==========================================
  // helpers
  function automatic logic forcedZero(input logic [SRC_W-1:0] s);
    forcedZero = (s == SRC_FAULT) || (s == SRC_LINE_CT) || (s == SRC_PRIMING) ||
                 (s == SRC_JOCKEY) || ((s >= SRC_PUMP1) && (s <= SRC_PUMP6));
  endfunction : forcedZero

  function automatic logic present(input int i, input logic ext, input logic rly);
    if (i < 2)
      present = ext;
    else if (i < 5)
      present = 1'b1;
    else
      present = rly;
  endfunction : present

  logic [NUM_OUT-1:0] evNow;
  logic [NUM_OUT-1:0] chanOn;

  // ==========================================
  // per-output event select; one list for relays and digital outputs
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++)
    begin : g_sel
      // source 0 is unassigned and never true; terminal control needs local/remote
      assign evNow[g] = (state_r.src[g] == SRC_NONE) ? 1'b0 :
                        (state_r.src[g] == SRC_TERMINAL) ?
                          (state_r.evSync[SRC_TERMINAL] & state_r.modSync[2]) :
                        state_r.evSync[state_r.src[g]];
      assign chanOn[g] = present(g, state_r.modSync[0], state_r.modSync[1]);
    end
  endgenerate

  // ==========================================
  // next state
  always_comb
  begin
    logic [ADDR_W-1:0]  idx;
    logic [BLK_SHIFT-1:0] ofs;
    logic               hit;
    logic               cyc;
    logic [DLY_W-1:0]   onLim;
    logic [DLY_W-1:0]   holdLim;
    logic               outLvl;
    idx = '0;
    ofs = '0;
    hit = 1'b0;
    cyc = 1'b0;
    onLim = '0;
    holdLim = '0;
    outLvl = 1'b0;
    state_nxt = state_r;

    state_nxt.evMeta = eventFlags;
    state_nxt.evSync = state_r.evMeta;
    state_nxt.modMeta = {2'b00, localRemoteInUse, relayModPresent, extIoPresent};
    state_nxt.modSync = state_r.modMeta;

    // millisecond timebase
    state_nxt.msPulse = 1'b0;
    if (state_r.tick >= 32'(TICK_LEN - 1))
    begin
      state_nxt.tick = '0;
      state_nxt.msPulse = 1'b1;
    end
    else
      state_nxt.tick = state_r.tick + 32'h1;

    // bus: one wait cycle, answer on second
    cyc = (read | write) & ~state_r.ack;
    state_nxt.ack = cyc;
    idx = ADDR_W'(address >> BLK_SHIFT);
    ofs = address[BLK_SHIFT-1:0];
    if (cyc && read)
    begin
      state_nxt.rdata = '0;
      if (address == OFS_STATUS)
        state_nxt.rdata = 32'(state_r.outs);
      else if (address == OFS_VIRT_SRC)
        state_nxt.rdata = 32'(state_r.modSync[4:3]);
      else if (idx < ADDR_W'(NUM_OUT) && chanOn[idx[2:0]])
      begin
        case (ofs)
          OFS_SOURCE[3:0]:   state_nxt.rdata = 32'(state_r.src[idx[2:0]]);
          OFS_ON_DELAY[3:0]: state_nxt.rdata = 32'(state_r.onDly[idx[2:0]]);
          OFS_POLARITY[3:0]: state_nxt.rdata = 32'(state_r.negPol[idx[2:0]]);
          OFS_HOLD[3:0]:     state_nxt.rdata = 32'(state_r.holdDly[idx[2:0]]);
          default:           state_nxt.rdata = '0;
        endcase
      end
    end
    state_nxt.modMeta[4:3] = virtualInputSource;
    hit = cyc && write && (idx < ADDR_W'(NUM_OUT)) && chanOn[idx[2:0]];
    if (hit)
    begin
      case (ofs)
        OFS_SOURCE[3:0]:
          state_nxt.src[idx[2:0]] = writedata[SRC_W-1:0];
        OFS_ON_DELAY[3:0]:
          if (writedata[DLY_W-1:0] <= ON_DELAY_MAX &&
              writedata[31:DLY_W] == '0)
            state_nxt.onDly[idx[2:0]] = writedata[DLY_W-1:0];
        OFS_POLARITY[3:0]:
          state_nxt.negPol[idx[2:0]] = writedata[0];
        OFS_HOLD[3:0]:
          if (writedata[DLY_W-1:0] <= HOLD_MAX &&
              writedata[31:DLY_W] == '0)
            state_nxt.holdDly[idx[2:0]] = writedata[DLY_W-1:0];
        default:
          state_nxt.src = state_r.src;
      endcase
    end

    // per-channel conditioning, identical for relays and digital outputs
    for (int i = 0; i < NUM_OUT; i++)
    begin
      if (forcedZero(state_nxt.src[i]))
      begin
        state_nxt.onDly[i] = DELAY_RESET;
        state_nxt.holdDly[i] = DELAY_RESET;
      end
      if (state_nxt.src[i] == SRC_LINE_CT)
        state_nxt.negPol[i] = 1'b0;
      onLim = state_r.onDly[i];
      holdLim = state_r.holdDly[i];
      case (chan_state_t'(state_r.st[i]))
        IDLE:
        begin
          state_nxt.cnt[i] = '0;
          if (evNow[i] && !state_r.evState[i])
          begin
            if (onLim == '0)
              state_nxt.evState[i] = 1'b1;
            else
              state_nxt.st[i] = ON_WAIT;
          end
          else if (!evNow[i] && state_r.evState[i])
          begin
            if (holdLim == '0)
              state_nxt.evState[i] = 1'b0;
            else
              state_nxt.st[i] = HOLD_WAIT;
          end
        end
        ON_WAIT:
          if (!evNow[i])
            state_nxt.st[i] = IDLE;
          else if (state_r.msPulse)
          begin
            if (state_r.cnt[i] + 16'h1 >= onLim)
            begin
              state_nxt.evState[i] = 1'b1;
              state_nxt.st[i] = IDLE;
            end
            else
              state_nxt.cnt[i] = state_r.cnt[i] + 16'h1;
          end
        HOLD_WAIT:
          if (evNow[i])
            state_nxt.st[i] = IDLE;
          else if (state_r.msPulse)
          begin
            if (state_r.cnt[i] + 16'h1 >= holdLim)
            begin
              state_nxt.evState[i] = 1'b0;
              state_nxt.st[i] = IDLE;
            end
            else
              state_nxt.cnt[i] = state_r.cnt[i] + 16'h1;
          end
        default:
          state_nxt.st[i] = IDLE;
      endcase
      // absent outputs stay de-energised
      outLvl = state_r.evState[i] ^ state_r.negPol[i];
      state_nxt.outs[i] = chanOn[i] & outLvl;
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign readdata    = state_r.rdata;
  assign waitrequest = ~state_r.ack;  // high while idle: no request sees an early answer
  assign outputs     = state_r.outs;

  // ==========================================
  // checks
  property p_zero_dly;
    @(posedge core_clk) disable iff (rst)
      forcedZero(state_r.src[3]) |-> (state_r.onDly[3] == '0 && state_r.holdDly[3] == '0);
  endproperty
  a_zero_dly: assert property (p_zero_dly) else $error("forced delay not zero");

  property p_contactor_pol;
    @(posedge core_clk) disable iff (rst)
      (state_r.src[3] == SRC_LINE_CT) |-> !state_r.negPol[3];
  endproperty
  a_contactor_pol: assert property (p_contactor_pol) else $error("contactor not positive");

  property p_on_limit;
    @(posedge core_clk) disable iff (rst)
      state_r.onDly[2] <= ON_DELAY_MAX && state_r.holdDly[2] <= HOLD_MAX;
  endproperty
  a_on_limit: assert property (p_on_limit) else $error("delay out of range");

  property p_polarity;
    @(posedge core_clk) disable iff (rst)
      chanOn[2] |=> outputs[2] == ($past(state_r.evState[2]) ^ $past(state_r.negPol[2]));
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity wrong");

  property p_absent;
    @(posedge core_clk) disable iff (rst)
      !state_r.modSync[0] |=> !outputs[0];
  endproperty
  a_absent: assert property (p_absent) else $error("absent output driven");

  property p_cancel;
    @(posedge core_clk) disable iff (rst)
      (state_r.st[2] == 2'(ON_WAIT) && !evNow[2]) |=> state_r.st[2] == 2'(IDLE) && !state_r.evState[2];
  endproperty
  a_cancel: assert property (p_cancel) else $error("pending change not cancelled");

  property p_unassigned;
    @(posedge core_clk) disable iff (rst)
      (state_r.src[3] == SRC_NONE) |-> !evNow[3];
  endproperty
  a_unassigned: assert property (p_unassigned) else $error("unassigned event true");

  property p_hold;
    @(posedge core_clk) disable iff (rst)
      (state_r.st[2] == 2'(HOLD_WAIT) && !evNow[2]) |=> state_r.evState[2] || $past(state_r.msPulse);
  endproperty
  a_hold: assert property (p_hold) else $error("hold released early");

  property p_on_wait;
    @(posedge core_clk) disable iff (rst)
      (state_r.st[2] == 2'(ON_WAIT) && evNow[2] && !state_r.msPulse)
      |=> !state_r.evState[2];
  endproperty
  a_on_wait: assert property (p_on_wait) else $error("output changed before delay");

  property p_on_zero;
    @(posedge core_clk) disable iff (rst)
      (state_r.st[0] == 2'(IDLE) && evNow[0] && !state_r.evState[0] && state_r.onDly[0] == '0)
      |=> state_r.evState[0];
  endproperty
  a_on_zero: assert property (p_on_zero) else $error("zero on-delay not immediate");

  property p_hold_zero;
    @(posedge core_clk) disable iff (rst)
      (state_r.st[0] == 2'(IDLE) && !evNow[0] && state_r.evState[0] && state_r.holdDly[0] == '0)
      |=> !state_r.evState[0];
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("zero hold not immediate");

  property p_hold_cancel;
    @(posedge core_clk) disable iff (rst)
      (state_r.st[2] == 2'(HOLD_WAIT) && evNow[2])
      |=> state_r.st[2] == 2'(IDLE) && state_r.evState[2];
  endproperty
  a_hold_cancel: assert property (p_hold_cancel) else $error("hold not cancelled");

  property p_dout_absent;
    @(posedge core_clk) disable iff (rst)
      !state_r.modSync[0]
      |=> !outputs[1];
  endproperty
  a_dout_absent: assert property (p_dout_absent) else $error("absent output driven");

  property p_relay_absent;
    @(posedge core_clk) disable iff (rst)
      !state_r.modSync[1]
      |=> !outputs[7];
  endproperty
  a_relay_absent: assert property (p_relay_absent) else $error("absent relay driven");

  property p_terminal;
    @(posedge core_clk) disable iff (rst)
      (state_r.src[6] == SRC_TERMINAL && !state_r.modSync[2])
      |-> !evNow[6];
  endproperty
  a_terminal: assert property (p_terminal) else $error("terminal event without local");

  property p_virt_read;
    @(posedge core_clk) disable iff (rst)
      (read && !state_r.ack && address == OFS_VIRT_SRC)
      |=> readdata == 32'($past(state_r.modSync[4:3]));
  endproperty
  a_virt_read: assert property (p_virt_read) else $error("virtual source read wrong");

  property p_range_five;
    @(posedge core_clk) disable iff (rst)
      state_r.onDly[5] <= ON_DELAY_MAX
      && state_r.holdDly[5] <= HOLD_MAX;
  endproperty
  a_range_five: assert property (p_range_five) else $error("relay delay out of range");

  property p_neg_pol;
    @(posedge core_clk) disable iff (rst)
      (chanOn[5] && state_r.negPol[5] && state_r.evState[5])
      |=> !outputs[5];
  endproperty
  a_neg_pol: assert property (p_neg_pol) else $error("negative polarity wrong");

  property p_refuse_on;
    @(posedge core_clk) disable iff (rst)
      (write && !state_r.ack && address[BLK_SHIFT-1:0] == OFS_ON_DELAY[BLK_SHIFT-1:0] &&
       writedata > 32'(ON_DELAY_MAX)) |=> state_r.onDly == $past(state_r.onDly);
  endproperty
  a_refuse_on: assert property (p_refuse_on) else $error("on-delay overrange taken");

  property p_refuse_hold;
    @(posedge core_clk) disable iff (rst)
      (write && !state_r.ack && address[BLK_SHIFT-1:0] == OFS_HOLD[BLK_SHIFT-1:0] &&
       writedata > 32'(HOLD_MAX)) |=> state_r.holdDly == $past(state_r.holdDly);
  endproperty
  a_refuse_hold: assert property (p_refuse_hold) else $error("hold overrange taken");

endmodule : drive_output_conditioner

// File: drive_output_conditioner_tb.sv
`timescale 1ns/1ps
module drive_output_conditioner_tb;
  import drive_output_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [7:0]  address = 8'h00;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [63:0] ev = 64'h0;
  logic        lr = 1'b0;
  logic        ext = 1'b1;
  logic        rm = 1'b1;
  logic [1:0]  vSrc = 2'h0;
  logic [7:0]  outs;
  logic [7:0]  coil;
  int          n_fail = 0;
  int          checks = 0;
  int          mSrc[8], mOn[8], mHold[8], mPol[8];
  int          d, h;
  // ==========================================
  // design and loads
  drive_output_conditioner #(.TICK_LEN(10)) dut (.core_clk(core_clk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .eventFlags(ev),
    .localRemoteInUse(lr), .extIoPresent(ext), .relayModPresent(rm),
    .virtualInputSource(vSrc), .outputs(outs));
  output_load_model load (.drive(outs), .energized(coil));
  always #20 core_clk = ~core_clk;
  // ==========================================
  // checking and bus tasks
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  // request held until waitrequest is sampled low, then released
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] dat, output logic [31:0] q);
    address <= a;
    writedata <= dat;
    read <= !wr;
    write <= wr;
    do
      @(posedge core_clk);
    while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  function automatic bit pres(int i);
    return i < 2 ? ext : (i > 4 ? rm : 1'b1);
  endfunction : pres
  function automatic bit fz(int s);
    return s >= 'h17 && s <= 'h20;
  endfunction : fz
  function automatic int ex(int i, int o);
    if (!pres(i))
      return 0;
    case (o)
      0: return mSrc[i];
      4: return fz(mSrc[i]) ? 0 : mOn[i];
      8: return mPol[i];
      default: return fz(mSrc[i]) ? 0 : mHold[i];
    endcase
  endfunction : ex
  // model only accepts what the block should accept
  task automatic wr(int i, int o, int v);
    logic [31:0] q;
    bus(1'b1, 8'(i * 16 + o), 32'(v), q);
    if (pres(i))
      case (o)
        0:
        begin
          mSrc[i] = v;
          if (fz(v))
          begin
            mOn[i] = 0;
            mHold[i] = 0;
          end
          if (v == SRC_LINE_CT)
            mPol[i] = 0;
        end
        4: if (!fz(mSrc[i]) && v <= 60000) mOn[i] = v;
        8: mPol[i] = (mSrc[i] == SRC_LINE_CT) ? 0 : v & 1;
        default: if (!fz(mSrc[i]) && v <= 9999) mHold[i] = v;
      endcase
  endtask : wr
  task automatic rdchk(int i, int o);
    logic [31:0] q;
    bus(1'b0, 8'(i * 16 + o), 32'h0, q);
    chk("setting", q, 32'(ex(i, o)));
  endtask : rdchk
  // output holds its old level for early cycles, then reaches e in lim
  task automatic expAfter(int i, logic e, int early, int lim);
    int n;
    n = 0;
    repeat (early) @(posedge core_clk);
    if (early > 0)
      chk("early", {31'h0, outs[i]}, {31'h0, !e});
    while (outs[i] !== e && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
    chk("output", {31'h0, outs[i]}, {31'h0, e});
    chk("coil", {31'h0, coil[i]}, {31'h0, e});
  endtask : expAfter
  // ==========================================
  // watchdog: whole run is well under this
  initial
  begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    complete_run;
  end
  // ==========================================
  // scenarios
  initial
  begin
    logic [31:0] q;
    void'($urandom(85016));
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 8; i++)
      for (int o = 0; o < 16; o += 4)
        rdchk(i, o);
    for (int v = 0; v < 4; v++)
    begin
      vSrc <= 2'(v);
      repeat (3) @(posedge core_clk);
      bus(1'b0, OFS_VIRT_SRC, 32'h0, q);
      chk("virtual", q, 32'(v));
    end
    bus(1'b1, OFS_VIRT_SRC, 32'h0, q);
    bus(1'b0, OFS_VIRT_SRC, 32'h0, q);
    chk("virtual", q, 32'h3);
    bus(1'b0, 8'h90, 32'h0, q);
    chk("unmapped", q, 32'h0);
    wr(2, 4, 60000);
    wr(2, 4, 60001);
    rdchk(2, 4);
    wr(2, 12, 9999);
    wr(2, 12, 10000);
    rdchk(2, 12);
    for (int s = 'h17; s <= 'h20; s++)
    begin
      wr(3, 0, s);
      wr(3, 4, 7);
      wr(3, 12, 7);
      rdchk(3, 4);
      rdchk(3, 12);
    end
    // every plain event code on a digital output, zero delays
    for (int s = 1; s <= 'h16; s++)
      if (s != 'h0C)
      begin
        wr(0, 0, s);
        rdchk(0, 0);
        ev[s] <= 1'b1;
        expAfter(0, 1'b1, 0, 8);
        ev[s] <= 1'b0;
        expAfter(0, 1'b0, 0, 8);
      end
    wr(6, 0, 'h0C);
    ev[12] <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk("terminal", {31'h0, outs[6]}, 32'h0);
    lr <= 1'b1;
    expAfter(6, 1'b1, 0, 8);
    d = $urandom_range(1, 3);
    h = $urandom_range(1, 3);
    wr(2, 0, 'h11);
    wr(2, 4, d);
    wr(2, 12, h);
    ev[17] <= 1'b1;
    expAfter(2, 1'b1, (d - 1) * 10, 18);
    ev[17] <= 1'b0;
    expAfter(2, 1'b0, (h - 1) * 10, 18);
    // long hold, so a missed cancel still shows high at the checks
    wr(2, 4, 2);
    wr(2, 12, 50);
    ev[17] <= 1'b1;
    repeat (3) @(posedge core_clk);
    ev[17] <= 1'b0;
    repeat (15) @(posedge core_clk);
    chk("revert", {31'h0, outs[2]}, 32'h0);
    repeat (25) @(posedge core_clk);
    chk("revert", {31'h0, outs[2]}, 32'h0);
    ev[17] <= 1'b1;
    expAfter(2, 1'b1, 0, 40);
    ev[17] <= 1'b0;
    repeat (3) @(posedge core_clk);
    ev[17] <= 1'b1;
    repeat (40) @(posedge core_clk);
    chk("revert", {31'h0, outs[2]}, 32'h1);
    wr(5, 0, 'h12);
    wr(5, 8, 1);
    expAfter(5, 1'b1, 0, 8);
    ev[18] <= 1'b1;
    expAfter(5, 1'b0, 0, 8);
    wr(4, 0, 'h18);
    wr(4, 8, 1);
    rdchk(4, 8);
    ev[24] <= 1'b1;
    expAfter(4, 1'b1, 0, 8);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk("status", q, 32'h54);
    wr(7, 0, 'h12);
    expAfter(7, 1'b1, 0, 8);
    rm <= 1'b0;
    expAfter(7, 1'b0, 0, 8);
    wr(7, 0, 5);
    rdchk(7, 0);
    rm <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdchk(7, 0);
    ext <= 1'b0;
    repeat (3) @(posedge core_clk);
    wr(0, 0, 3);
    rdchk(0, 0);
    ext <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdchk(0, 0);
    // reset in mid-run returns every setting to its default
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      mSrc[i] = 0;
      mOn[i] = 0;
      mHold[i] = 0;
      mPol[i] = 0;
    end
    repeat (3) @(posedge core_clk);
    chk("reset outs", {24'h0, outs}, 32'h0);
    rdchk(2, 4);
    rdchk(2, 12);
    rdchk(5, 8);
    rdchk(4, 0);
    complete_run;
  end
endmodule : drive_output_conditioner_tb

// File: drive_output_pkg.sv
// Operation
// - on-delay counted in 1 ms steps
// - on-delay 0 to 60000 ms, reset 0
// - hold state for holding time on fall
// - holding time 0 to 9999 ms, reset 0
// - pump/contactor/fault sources force zero delays
// - polarity positive drives 1, negative 0
// - line contactor forces positive polarity
// - digital outputs only with extended module
// - relays 1-3 always, 4-6 with module
// - relays share the same four settings
// - digital outputs share relay source list
// - source defaults unassigned, warning groups 1-5
// - loop loss warning per analog input
// - terminal control event, local/remote only
// - parameter set 1-3 active events
// - config zero, bus, external, torque events
// - current and frequency-2 threshold events
// - virtual input source read-only, four values
package drive_output_pkg;

  localparam int CLK_HZ        = 25000000;
  localparam int TICK_MS       = 1;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int NUM_OUT       = 8;
  localparam int NUM_SRC       = 64;
  localparam int SRC_W         = 6;
  localparam int DLY_W         = 16;
  localparam logic [15:0] ON_DELAY_MAX  = 16'hEA60;
  localparam logic [15:0] HOLD_MAX      = 16'h270F;
  localparam logic [15:0] DELAY_RESET   = 16'h0000;

  // source codes
  localparam logic [5:0] SRC_NONE      = 6'h00;
  localparam logic [5:0] SRC_WARN_GRP1 = 6'h01;
  localparam logic [5:0] SRC_LOOP_LOSS1 = 6'h06;
  localparam logic [5:0] SRC_TORQUE    = 6'h0B;
  localparam logic [5:0] SRC_TERMINAL  = 6'h0C;
  localparam logic [5:0] SRC_PSET1     = 6'h0D;
  localparam logic [5:0] SRC_CFG0      = 6'h10;
  localparam logic [5:0] SRC_CUR_HI    = 6'h11;
  localparam logic [5:0] SRC_CUR_LO    = 6'h12;
  localparam logic [5:0] SRC_BUS       = 6'h13;
  localparam logic [5:0] SRC_EXT_ERR   = 6'h14;
  localparam logic [5:0] SRC_F2_HI     = 6'h15;
  localparam logic [5:0] SRC_F2_LO     = 6'h16;
  localparam logic [5:0] SRC_FAULT     = 6'h17;
  localparam logic [5:0] SRC_LINE_CT   = 6'h18;
  localparam logic [5:0] SRC_PRIMING   = 6'h19;
  localparam logic [5:0] SRC_JOCKEY    = 6'h1A;
  localparam logic [5:0] SRC_PUMP1     = 6'h1B;
  localparam logic [5:0] SRC_PUMP6     = 6'h20;

  // register map: per output a block of four words
  localparam int ADDR_W        = 8;
  localparam logic [7:0] OFS_SOURCE    = 8'h00;
  localparam logic [7:0] OFS_ON_DELAY  = 8'h04;
  localparam logic [7:0] OFS_POLARITY  = 8'h08;
  localparam logic [7:0] OFS_HOLD      = 8'h0C;
  localparam logic [7:0] OFS_STATUS    = 8'h80;
  localparam logic [7:0] OFS_VIRT_SRC  = 8'h84;
  localparam int BLK_SHIFT     = 4;

  localparam logic [1:0] VIRT_NONE     = 2'h0;
  localparam logic [1:0] VIRT_PID      = 2'h1;
  localparam logic [1:0] VIRT_INST     = 2'h2;
  localparam logic [1:0] VIRT_PUMP     = 2'h3;

  typedef enum logic [1:0] {IDLE, ON_WAIT, HOLD_WAIT} chan_state_t;

endpackage : drive_output_pkg

// File: output_load_model.sv
`timescale 1ns/1ps
// ==========================================
// relay coil and output load model
module output_load_model (
  input  wire logic [7:0] drive,
  output logic      [7:0] energized
);
  // coils follow the drive; no contact bounce modelled
  assign energized = drive;
endmodule : output_load_model
